// *** src/awfs_sync_feedback.sv ***
// Purpose: feedback selection and sampling plus the start barrier of the generator cores
// Assumes: link and hub pins are asynchronous; analyzer data and core signals share core_clk
// Notes: link data and trigger see two sync stages; APB is zero wait state
`timescale 1ns/1ps
module awfs_sync_feedback #(
  parameter int NCORE = 4,
  parameter int FB_W = 32,
  parameter int LAT_W = 12,
  parameter int IDX_W = 10
) (
  input logic core_clk,
  input logic resetn,
  input logic ce,
  input logic [7:0] paddr,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input logic cmd_valid,
  input awfs_pkg::awfs_op_t cmd_op,
  input awfs_pkg::awfs_src_t cmd_src,
  input logic [LAT_W-1:0] cmd_latency,
  input logic [$clog2(FB_W)-1:0] cmd_lsb,
  input logic [$clog2(FB_W):0] cmd_size,
  input logic [FB_W-1:0] cmd_offset,
  output logic cmd_ready,
  output logic rsp_valid,
  output logic rsp_is_index,
  output logic rsp_err,
  output logic [FB_W-1:0] rsp_value,
  output logic [IDX_W-1:0] rsp_table_index,
  input logic link_trigger,
  input logic [FB_W-1:0] link_msg,
  input logic [FB_W-1:0] analyzer_msg,
  input logic [NCORE-1:0] core_prefetch_done,
  output logic [NCORE-1:0] core_go,
  output logic hub_ready,
  input logic hub_release,
  output logic int_trigger,
  input logic rate_ovr_valid,
  input logic [awfs_pkg::RATE_W-1:0] rate_ovr_exp,
  output logic [awfs_pkg::RATE_W-1:0] rate_exp
);
  import awfs_pkg::*;
  localparam int SW = $clog2(FB_W);
  localparam logic [SW:0] FULL = (SW+1)'(FB_W);

  if (NCORE < 1 || NCORE > 16 || FB_W < 2 || FB_W > 32 || IDX_W < 1 || IDX_W > FB_W || LAT_W < 1)
  begin : g_bad
    $error("awfs_sync_feedback: unsupported parameters");
  end

  // Pin synchronisers; second stages and the edge-detect delay flops are read
  logic trig_s1_r, trig_s2_r, trig_d_r, rel_s1_r, rel_s2_r, rel_d_r;
  logic [FB_W-1:0] msg_s1_r, msg_s2_r;
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      trig_s1_r <= 1'b0;
      trig_s2_r <= 1'b0;
      trig_d_r <= 1'b0;
      rel_s1_r <= 1'b0;
      rel_s2_r <= 1'b0;
      rel_d_r <= 1'b0;
      msg_s1_r <= '0;
      msg_s2_r <= '0;
    end
    else if (ce)
    begin
      trig_s1_r <= link_trigger;
      trig_s2_r <= trig_s1_r;
      trig_d_r <= trig_s2_r;
      rel_s1_r <= hub_release;
      rel_s2_r <= rel_s1_r;
      rel_d_r <= rel_s2_r;
      msg_s1_r <= link_msg;
      msg_s2_r <= msg_s1_r;
    end
  end
  logic trig_edge, hub_edge;
  assign trig_edge = trig_s2_r & ~trig_d_r;
  assign hub_edge = rel_s2_r & ~rel_d_r;

  // Register file
  logic [31:0] ctrl_r, ctrl_nxt, trig_cfg_r, trig_cfg_nxt, prdata_r, prdata_nxt, rd_mux;
  logic [RATE_W-1:0] rate_def_r, rate_def_nxt, rate_cur_r, rate_cur_nxt;
  logic mapped, apb_setup, apb_wr;
  logic [NCORE-1:0] en_mask, ready_r, ready_nxt, go_r, go_nxt;
  logic src_ext, tsync, hub_ready_r, hub_ready_nxt, local_ok, go_now, trig_idle, tseen_r, tseen_nxt;
  logic [FB_W-1:0] rsp_val_r, rsp_val_nxt;

  assign en_mask = ctrl_r[CTRL_EN_LSB +: NCORE];
  assign src_ext = ctrl_r[CTRL_SRC_BIT];
  assign tsync = ctrl_r[CTRL_TSYNC_BIT];
  assign apb_setup = psel & ~penable;
  assign apb_wr = psel & penable & pwrite;

  always_comb
  begin
    mapped = 1'b1;
    rd_mux = '0;
    case (paddr)
      REG_CTRL: rd_mux = ctrl_r;
      REG_STATUS:
      begin
        rd_mux[STAT_HUB_BIT] = hub_ready_r;
        rd_mux[STAT_TBUSY_BIT] = ~trig_idle;
        rd_mux[STAT_TSEEN_BIT] = tseen_r;
        rd_mux[STAT_RDY_LSB +: NCORE] = ready_r;
      end
      REG_TRIG: rd_mux = trig_cfg_r;
      REG_RATE: rd_mux[RATE_W-1:0] = rate_def_r;
      REG_FB_LAST: rd_mux[FB_W-1:0] = rsp_val_r;
      default: mapped = 1'b0;
    endcase
  end

  always_comb
  begin
    ctrl_nxt = ctrl_r;
    trig_cfg_nxt = trig_cfg_r;
    rate_def_nxt = rate_def_r;
    prdata_nxt = apb_setup ? rd_mux : prdata_r;
    if (apb_wr)
    begin
      case (paddr)
        REG_CTRL:
        begin
          ctrl_nxt = '0;
          ctrl_nxt[CTRL_SRC_BIT] = pwdata[CTRL_SRC_BIT];
          ctrl_nxt[CTRL_TSYNC_BIT] = pwdata[CTRL_TSYNC_BIT];
          ctrl_nxt[CTRL_EN_LSB +: NCORE] = pwdata[CTRL_EN_LSB +: NCORE];
        end
        REG_TRIG: trig_cfg_nxt = pwdata & TRIG_MASK;
        REG_RATE:
        begin
          if (pwdata <= 32'(RATE_MAX))
            rate_def_nxt = pwdata[RATE_W-1:0]; // see RULE13
        end
        default: ctrl_nxt = ctrl_r;
      endcase
    end
    // Each new run starts at the default rate; the program may override
    rate_cur_nxt = rate_cur_r;
    if (go_now)
      rate_cur_nxt = rate_def_r; // see RULE13
    else if (rate_ovr_valid && rate_ovr_exp <= RATE_MAX)
      rate_cur_nxt = rate_ovr_exp; // see RULE13
  end

  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      ctrl_r <= CTRL_RST;
      trig_cfg_r <= TRIG_RST;
      rate_def_r <= RATE_RST;
      rate_cur_r <= RATE_RST;
      prdata_r <= '0;
    end
    else if (ce)
    begin
      ctrl_r <= ctrl_nxt;
      trig_cfg_r <= trig_cfg_nxt;
      rate_def_r <= rate_def_nxt;
      rate_cur_r <= rate_cur_nxt;
      prdata_r <= prdata_nxt;
    end
  end
  assign prdata = prdata_r;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign rate_exp = rate_cur_r;

  // Feedback sampling
  awfs_proc_if #(.W(FB_W)) pif();
  awfs_fb_proc #(.W(FB_W)) u_proc (.core_clk(core_clk), .resetn(resetn), .ce(ce), .p(pif.proc));

  awfs_fb_st_t fb_r, fb_nxt;
  awfs_op_t op_q_r, op_q_nxt;
  awfs_src_t src_q_r, src_q_nxt;
  logic [LAT_W-1:0] lat_q_r, lat_q_nxt, age_r, age_nxt;
  logic [SW-1:0] cfg_lsb_r [SLOTS], cfg_lsb_nxt [SLOTS];
  logic [SW:0] cfg_size_r [SLOTS], cfg_size_nxt [SLOTS];
  logic [FB_W-1:0] cfg_off_r [SLOTS], cfg_off_nxt [SLOTS];
  logic rsp_v_r, rsp_v_nxt, rsp_kind_r, rsp_kind_nxt, rsp_err_r, rsp_err_nxt, cmd_take, proc_start;

  assign cmd_ready = ce && (fb_r == st_idle);
  assign cmd_take = cmd_valid & cmd_ready;

  always_comb
  begin
    fb_nxt = fb_r;
    op_q_nxt = op_q_r;
    src_q_nxt = src_q_r;
    lat_q_nxt = lat_q_r;
    cfg_lsb_nxt = cfg_lsb_r;
    cfg_size_nxt = cfg_size_r;
    cfg_off_nxt = cfg_off_r;
    rsp_v_nxt = 1'b0;
    rsp_err_nxt = 1'b0;
    rsp_kind_nxt = rsp_kind_r;
    rsp_val_nxt = rsp_val_r;
    proc_start = 1'b0;
    age_nxt = (tseen_r && age_r != '1) ? age_r + 1'b1 : age_r;
    tseen_nxt = tseen_r;
    if (cmd_take && cmd_op == wait_link_trigger_cmd)
      tseen_nxt = 1'b0;
    // A trigger in the re-arm cycle is kept
    if (trig_edge)
    begin
      tseen_nxt = 1'b1;
      age_nxt = '0;
    end
    if (cmd_take && cmd_op == feedback_proc_config_cmd && !is_raw(cmd_src))
    begin
      cfg_lsb_nxt[slot_of(cmd_src)] = cmd_lsb; // see RULE2
      cfg_size_nxt[slot_of(cmd_src)] = cmd_size;
      cfg_off_nxt[slot_of(cmd_src)] = cmd_offset;
    end
    case (fb_r)
      st_idle:
      begin
        if (cmd_take && (cmd_op == feedback_read_cmd || cmd_op == play_table_entry_cmd))
        begin
          if (cmd_op == play_table_entry_cmd && is_raw(cmd_src))
          begin
            rsp_v_nxt = 1'b1; // see RULE6
            rsp_err_nxt = 1'b1;
            rsp_kind_nxt = 1'b1;
          end
          else
          begin
            op_q_nxt = cmd_op;
            src_q_nxt = cmd_src;
            lat_q_nxt = cmd_latency;
            fb_nxt = st_wait;
          end
        end
      end
      st_wait:
      begin
        if (tseen_r && age_r == lat_q_r)
        begin
          proc_start = 1'b1; // see RULE4 RULE5
          fb_nxt = st_proc;
        end
        else if (tseen_r && age_r > lat_q_r)
        begin
          // Sample point already passed; no stale data is returned
          rsp_v_nxt = 1'b1;
          rsp_err_nxt = 1'b1;
          rsp_kind_nxt = (op_q_r == play_table_entry_cmd);
          fb_nxt = st_idle;
        end
      end
      st_proc:
      begin
        if (pif.done)
        begin
          rsp_v_nxt = 1'b1;
          rsp_kind_nxt = (op_q_r == play_table_entry_cmd); // see RULE1
          rsp_val_nxt = pif.result;
          fb_nxt = st_idle;
        end
      end
      default: fb_nxt = st_idle;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      fb_r <= st_idle;
      op_q_r <= feedback_read_cmd;
      src_q_r <= link_feedback_unprocessed;
      lat_q_r <= '0;
      age_r <= '0;
      tseen_r <= 1'b0;
      for (int i = 0; i < SLOTS; i++)
      begin
        cfg_lsb_r[i] <= '0;
        cfg_size_r[i] <= FULL; // see RULE2
        cfg_off_r[i] <= '0;
      end
      rsp_v_r <= 1'b0;
      rsp_err_r <= 1'b0;
      rsp_kind_r <= 1'b0;
      rsp_val_r <= '0;
    end
    else if (ce)
    begin
      fb_r <= fb_nxt;
      op_q_r <= op_q_nxt;
      src_q_r <= src_q_nxt;
      lat_q_r <= lat_q_nxt;
      age_r <= age_nxt;
      tseen_r <= tseen_nxt;
      cfg_lsb_r <= cfg_lsb_nxt;
      cfg_size_r <= cfg_size_nxt;
      cfg_off_r <= cfg_off_nxt;
      rsp_v_r <= rsp_v_nxt;
      rsp_err_r <= rsp_err_nxt;
      rsp_kind_r <= rsp_kind_nxt;
      rsp_val_r <= rsp_val_nxt;
    end
  end

  assign pif.start = proc_start;
  assign pif.bypass = is_raw(src_q_r); // see RULE3 RULE6
  assign pif.msg = is_link(src_q_r) ? msg_s2_r : analyzer_msg;
  assign pif.lsb = cfg_lsb_r[slot_of(src_q_r)];
  assign pif.size = cfg_size_r[slot_of(src_q_r)];
  assign pif.offset = cfg_off_r[slot_of(src_q_r)];
  assign rsp_valid = rsp_v_r;
  assign rsp_err = rsp_err_r;
  assign rsp_is_index = rsp_kind_r;
  assign rsp_value = rsp_val_r;
  assign rsp_table_index = rsp_val_r[IDX_W-1:0];

  // Start barrier and internal trigger unit
  logic [TRIG_CNT_W-1:0] tleft_r, tleft_nxt;
  logic [TRIG_HOLD_W-1:0] thold_r, thold_nxt;
  logic tpulse_r, tpulse_nxt;

  assign trig_idle = (tleft_r == '0);
  assign local_ok = (&(ready_r | ~en_mask)) && (|(ready_r & en_mask)) && (!tsync || trig_idle); // see RULE9 RULE12
  assign go_now = local_ok && (!src_ext || (hub_ready_r && hub_edge)); // see RULE10 RULE11

  always_comb
  begin
    // Prefetch done marks an enabled core ready; a new ready beats the release clear
    ready_nxt = (ready_r & ~({NCORE{go_now}} & en_mask)) | (core_prefetch_done & en_mask); // see RULE8
    go_nxt = (core_prefetch_done & ~en_mask) | ({NCORE{go_now}} & en_mask); // see RULE7 RULE14
    hub_ready_nxt = src_ext && local_ok && !go_now; // see RULE10 RULE11
    tleft_nxt = tleft_r;
    thold_nxt = thold_r;
    tpulse_nxt = 1'b0;
    if (go_now)
    begin
      tleft_nxt = trig_cfg_r[TRIG_CNT_LSB +: TRIG_CNT_W]; // see RULE12
      thold_nxt = '0;
    end
    else if (!trig_idle)
    begin
      if (thold_r == '0)
      begin
        tpulse_nxt = 1'b1;
        tleft_nxt = tleft_r - 1'b1;
        thold_nxt = trig_cfg_r[TRIG_HOLD_LSB +: TRIG_HOLD_W];
      end
      else
        thold_nxt = thold_r - 1'b1;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      ready_r <= '0;
      go_r <= '0;
      hub_ready_r <= 1'b0;
      tleft_r <= '0;
      thold_r <= '0;
      tpulse_r <= 1'b0;
    end
    else if (ce)
    begin
      ready_r <= ready_nxt;
      go_r <= go_nxt;
      hub_ready_r <= hub_ready_nxt;
      tleft_r <= tleft_nxt;
      thold_r <= thold_nxt;
      tpulse_r <= tpulse_nxt;
    end
  end
  assign core_go = go_r;
  assign hub_ready = hub_ready_r;
  assign int_trigger = tpulse_r;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!resetn);

  go_aligned_a: assert property (ce && go_now |=> (core_go & $past(en_mask)) == $past(en_mask)) // see RULE14
    else $error("participants not released together");
  no_early_go_a: assert property (ce && !go_now |=> (core_go & $past(en_mask)) == '0) // see RULE9
    else $error("participant started before the barrier");
  skip_check_a: assert property (ce && core_prefetch_done[0] && !en_mask[0] |=> core_go[0]) // see RULE7
    else $error("non-participant was held");
  ready_first_a: assert property (go_now |-> (ready_r & en_mask) != '0) // see RULE8
    else $error("release without a finished prefetch");
  hub_quiet_a: assert property (ce && !src_ext |=> !hub_ready) // see RULE11
    else $error("hub ready driven with internal source");
  hub_gate_a: assert property (go_now && src_ext |-> hub_ready && hub_edge) // see RULE10
    else $error("external release without hub");
  trig_gate_a: assert property (go_now && tsync |-> trig_idle) // see RULE12
    else $error("release while trigger burst runs");
  exact_lat_a: assert property (proc_start |-> tseen_r && age_r == lat_q_r) // see RULE4 RULE5
    else $error("feedback sampled at the wrong latency");
  raw_value_a: assert property (ce && proc_start && src_q_r == link_feedback_unprocessed ##1 ce // see RULE3
    |=> rsp_valid && rsp_value == $past(msg_s2_r, 2))
    else $error("raw link feedback was changed");
  play_raw_a: assert property (ce && cmd_take && cmd_op == play_table_entry_cmd && is_raw(cmd_src) // see RULE6
    |=> rsp_valid && rsp_err)
    else $error("raw source accepted for table play");
  rsp_kind_a: assert property (ce && fb_r == st_proc && pif.done // see RULE1
    |=> rsp_valid && !rsp_err && rsp_is_index == ($past(op_q_r) == play_table_entry_cmd))
    else $error("feedback returned in the wrong form");
  rate_range_a: assert property (rate_exp <= RATE_MAX) // see RULE13
    else $error("rate exponent out of range");

  ext_release_c: cover property (go_now && src_ext);
  late_err_c: cover property (rsp_valid && rsp_err && !rsp_is_index);
  play_rsp_c: cover property (rsp_valid && rsp_is_index && !rsp_err);
  burst_c: cover property (int_trigger ##1 !int_trigger [*2] ##1 int_trigger);
endmodule : awfs_sync_feedback

// *** src/awfs_pkg.sv ***
// Purpose: constants and types of the feedback selector and start barrier
// Assumes: one sequencer clock; registers reached over APB
// Notes: offsets are byte addresses of aligned 32-bit words
// Operation
// RULE1 - Feedback can come back as a value for a variable or as a table-entry index to play.
// RULE2 - Processing keeps a chosen bit range and adds an offset; unconfigured means whole message, offset zero.
// RULE3 - The raw link source passes the message unchanged, with no trim and no offset.
// RULE4 - Playing a table entry from feedback uses the processed value present the set latency after the trigger.
// RULE5 - A feedback read returns the data present exactly the set latency in cycles after the trigger.
// RULE6 - Analyzer feedback is readable raw or processed; only its processed form, like link A and B, picks entries.
// RULE7 - A core with its sync enable set joins the start check; one with it cleared skips it.
// RULE8 - The check runs after prefetch has filled internal memory and before the first instruction.
// RULE9 - Each joining core reports ready and stalls until every participant is ready.
// RULE10 - With external source the combined ready goes to the hub, which releases once all instruments are ready.
// RULE11 - With internal source only local enabled cores take part and the hub ignores this instrument.
// RULE12 - With trigger sync on, the trigger unit joins the check and emits the same burst between checks.
// RULE13 - The sample rate is the base rate over two to an exponent of 0 to 13, overridable by the program.
// RULE14 - All participating cores are released in the same clock cycle.
package awfs_pkg;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_TRIG = 8'h08;
  localparam logic [7:0] REG_RATE = 8'h0C;
  localparam logic [7:0] REG_FB_LAST = 8'h10;
  localparam int CTRL_SRC_BIT = 0;
  localparam int CTRL_TSYNC_BIT = 1;
  localparam int CTRL_EN_LSB = 8;
  localparam int STAT_HUB_BIT = 0;
  localparam int STAT_TBUSY_BIT = 1;
  localparam int STAT_TSEEN_BIT = 2;
  localparam int STAT_RDY_LSB = 8;
  localparam int TRIG_CNT_LSB = 0;
  localparam int TRIG_CNT_W = 8;
  localparam int TRIG_HOLD_LSB = 8;
  localparam int TRIG_HOLD_W = 16;
  localparam logic [31:0] TRIG_MASK = 32'h00FFFFFF;
  localparam int RATE_W = 4;
  localparam logic [RATE_W-1:0] RATE_MAX = 4'hD;
  localparam logic [31:0] CTRL_RST = 32'h00000000;
  localparam logic [31:0] TRIG_RST = 32'h00000000;
  localparam logic [RATE_W-1:0] RATE_RST = 4'h0;
  localparam int SLOTS = 3;

  typedef enum logic [2:0] {
    link_feedback_processed_a,
    link_feedback_processed_b,
    link_feedback_unprocessed,
    analyzer_feedback_unprocessed,
    analyzer_feedback_trimmed
  } awfs_src_t;

  typedef enum logic [1:0] {
    feedback_read_cmd,
    play_table_entry_cmd,
    feedback_proc_config_cmd,
    wait_link_trigger_cmd
  } awfs_op_t;

  typedef enum logic [1:0] {st_idle, st_wait, st_proc} awfs_fb_st_t;

  function automatic logic is_raw(input awfs_src_t s);
    return (s == link_feedback_unprocessed) || (s == analyzer_feedback_unprocessed);
  endfunction : is_raw

  function automatic logic is_link(input awfs_src_t s);
    return (s == link_feedback_processed_a) || (s == link_feedback_processed_b) ||
           (s == link_feedback_unprocessed);
  endfunction : is_link

  function automatic logic [1:0] slot_of(input awfs_src_t s);
    logic [1:0] k;
    k = 2'h0;
    if (s == link_feedback_processed_b)
      k = 2'h1;
    else if (s == analyzer_feedback_trimmed)
      k = 2'h2;
    return k;
  endfunction : slot_of
endpackage : awfs_pkg

// *** src/awfs_proc_if.sv ***
// Purpose: carries one processing request and its result
// Assumes: same clock on both ends
// Notes: result is valid in the cycle done is high
`timescale 1ns/1ps
interface awfs_proc_if #(parameter int W = 32);
  logic start;
  logic bypass;
  logic [W-1:0] msg;
  logic [$clog2(W)-1:0] lsb;
  logic [$clog2(W):0] size;
  logic [W-1:0] offset;
  logic done;
  logic [W-1:0] result;
  modport main (output start, bypass, msg, lsb, size, offset, input done, result);
  modport proc (input start, bypass, msg, lsb, size, offset, output done, result);
endinterface : awfs_proc_if

// *** src/awfs_fb_proc.sv ***
// Purpose: trims a feedback message to a bit field and adds an offset
// Assumes: one request per start pulse
// Notes: one cycle from start to done
`timescale 1ns/1ps
module awfs_fb_proc #(
  parameter int W = 32
) (
  input logic core_clk,
  input logic resetn,
  input logic ce,
  awfs_proc_if.proc p
);
  import awfs_pkg::*;
  localparam int SW = $clog2(W);
  localparam logic [SW:0] FULL = (SW+1)'(W);

  logic [W-1:0] result_r;
  logic [W-1:0] result_nxt;
  logic done_r;
  logic done_nxt;

  if (W < 2)
  begin : g_bad
    $error("awfs_fb_proc: width too small");
  end

  function automatic logic [W-1:0] keep_mask(input logic [SW:0] n);
    logic [W-1:0] m;
    m = '1;
    if (n < FULL)
      m = ~(m << n);
    return m;
  endfunction : keep_mask

  always_comb
  begin
    done_nxt = p.start;
    result_nxt = result_r;
    if (p.start)
    begin
      if (p.bypass)
        result_nxt = p.msg; // see RULE3
      else
        result_nxt = ((p.msg >> p.lsb) & keep_mask(p.size)) + p.offset; // see RULE2
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      result_r <= '0;
      done_r <= 1'b0;
    end
    else if (ce)
    begin
      result_r <= result_nxt;
      done_r <= done_nxt;
    end
  end

  assign p.result = result_r;
  assign p.done = done_r;

  untrimmed_pass_a: assert property (@(posedge core_clk) disable iff (!resetn) // see RULE2
    ce && p.start && !p.bypass && p.size == FULL && p.lsb == '0 && p.offset == '0
    |=> p.done && p.result == $past(p.msg))
    else $error("default processing altered the message");
  raw_pass_a: assert property (@(posedge core_clk) disable iff (!resetn) // see RULE3
    ce && p.start && p.bypass |=> p.done && p.result == $past(p.msg))
    else $error("raw message was processed");
endmodule : awfs_fb_proc

// *** sim/awfs_hub_model.sv ***
// Purpose: hub at the far side of the start barrier
// Assumes: only this instrument is connected to the hub
// Notes: release holds until the instrument drops its ready
`timescale 1ns/1ps
module awfs_hub_model (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic hub_ready,
  output logic hub_release
);
  logic [3:0] wait_r;
  // Slow on purpose, so the instrument must stall for the hub
  always_ff @(posedge core_clk)
  begin
    if (!resetn || !hub_ready)
    begin
      wait_r <= 4'h0;
      hub_release <= 1'b0;
    end
    else
    begin
      wait_r <= wait_r + 4'h1;
      if (wait_r == 4'h4)
        hub_release <= 1'b1;
    end
  end
endmodule : awfs_hub_model

// *** sim/tb.sv ***
// Purpose: self-checking bench of the feedback selector and start barrier
// Assumes: hub model at the far side; APB master in the bench
// Notes: link trigger timing is checked within the sync uncertainty
`timescale 1ns/1ps
module tb;
  import awfs_pkg::*;
  logic core_clk = 0, resetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q, e;
  logic pready, pslverr, cmd_valid = 0, cmd_ready, rsp_valid, rsp_is_index, rsp_err, hr, er;
  awfs_op_t cmd_op = feedback_read_cmd;
  awfs_src_t cmd_src = link_feedback_processed_a;
  logic [11:0] cmd_latency = 12'h000;
  logic [4:0] cmd_lsb = 5'h00;
  logic [5:0] cmd_size = 6'h20;
  logic [31:0] cmd_offset = 32'h0, rsp_value, link_msg = 32'hA5C31E74, analyzer_msg = 32'h00000F0F;
  logic [9:0] rsp_table_index;
  logic link_trigger = 0, hub_ready, hub_release, int_trigger, rate_ovr_valid = 0;
  logic [3:0] core_prefetch_done = 4'h0, core_go, go, rate_exp, rate_ovr_exp = 4'h0;
  int fails = 0, cmp_count = 0, n, nt;

  awfs_sync_feedback i_awfs_sync_feedback (.core_clk, .resetn, .ce, .paddr, .psel, .penable,
    .pwrite, .pwdata, .prdata, .pready, .pslverr, .cmd_valid, .cmd_op, .cmd_src, .cmd_latency,
    .cmd_lsb, .cmd_size, .cmd_offset, .cmd_ready, .rsp_valid, .rsp_is_index, .rsp_err, .rsp_value,
    .rsp_table_index, .link_trigger, .link_msg, .analyzer_msg, .core_prefetch_done, .core_go,
    .hub_ready, .hub_release, .int_trigger, .rate_ovr_valid, .rate_ovr_exp, .rate_exp);
  awfs_hub_model i_awfs_hub_model (.core_clk, .resetn, .hub_ready, .hub_release);

  initial forever #20 core_clk = ~core_clk;
  initial
  begin
    #400000;
    fails++;
    $display("ERROR t=%0t watchdog timeout", $time);
    results();
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      fails++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (pready !== 1'b1);
    q = prdata;
    e = {31'h0, pslverr};
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask : apb

  task automatic cmd(input awfs_op_t op, input awfs_src_t s, input logic [11:0] lat,
                     input logic [4:0] lsb, input logic [5:0] size, input logic [31:0] off);
    cmd_op <= op;
    cmd_src <= s;
    cmd_latency <= lat;
    cmd_lsb <= lsb;
    cmd_size <= size;
    cmd_offset <= off;
    cmd_valid <= 1'b1;
    n = 0;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (cmd_ready !== 1'b1);
    // Valid stays up between commands; fb lowers it
  endtask : cmd

  // Arms the trigger, issues one read or play, then fires the link trigger
  task automatic fb(input awfs_op_t op, input awfs_src_t s, input logic [11:0] lat);
    cmd(wait_link_trigger_cmd, s, 12'h000, 5'h00, 6'h20, 32'h0);
    cmd(op, s, lat, 5'h00, 6'h20, 32'h0);
    cmd_valid <= 1'b0;
    link_trigger <= 1'b1;
    nt = 0;
    do
    begin
      @(posedge core_clk);
      nt++;
    end
    while (rsp_valid !== 1'b1);
    // Error flag stands only with the response pulse
    er = rsp_err;
    link_trigger <= 1'b0;
    repeat (4) @(posedge core_clk);
  endtask : fb

  task automatic t_regs();
    apb(1'b0, REG_CTRL, 32'h0);
    chk(q, CTRL_RST);
    apb(1'b0, REG_TRIG, 32'h0);
    chk(q, TRIG_RST);
    apb(1'b0, 8'h20, 32'h0);
    chk(e, 32'h1);
    apb(1'b1, REG_RATE, 32'h0000000E);
    apb(1'b0, REG_RATE, 32'h0);
    chk(q, 32'h0);
    apb(1'b1, REG_RATE, 32'h0000000D);
    apb(1'b0, REG_RATE, 32'h0);
    chk(q, 32'h0000000D);
  endtask : t_regs

  task automatic t_fb();
    fb(feedback_read_cmd, link_feedback_unprocessed, 12'h007);
    chk(rsp_value, link_msg);
    chk(32'(nt >= 12 && nt <= 14), 32'h1);
    chk({31'h0, rsp_is_index}, 32'h0);
    chk({31'h0, er}, 32'h0);
    fb(feedback_read_cmd, link_feedback_processed_b, 12'h002);
    chk(rsp_value, link_msg);
    cmd(feedback_proc_config_cmd, link_feedback_processed_a, 12'h000, 5'h04, 6'h03, 32'h1);
    fb(play_table_entry_cmd, link_feedback_processed_a, 12'h003);
    chk({22'h0, rsp_table_index}, 32'h8);
    chk({30'h0, rsp_is_index, er}, 32'h2);
    fb(play_table_entry_cmd, link_feedback_unprocessed, 12'h003);
    chk({31'h0, er}, 32'h1);
    fb(feedback_read_cmd, analyzer_feedback_unprocessed, 12'h001);
    chk(rsp_value, analyzer_msg);
    cmd(feedback_proc_config_cmd, analyzer_feedback_trimmed, 12'h000, 5'h00, 6'h04, 32'h2);
    fb(play_table_entry_cmd, analyzer_feedback_trimmed, 12'h001);
    chk({22'h0, rsp_table_index}, 32'h11);
    apb(1'b0, REG_FB_LAST, 32'h0);
    chk(q, 32'h00000011);
  endtask : t_fb

  // First prefetch set must not release; second one completes the barrier or is a non-participant that skips it
  task automatic bar(input logic [31:0] ctrl, input logic [3:0] pf1, input logic [3:0] pf2,
                     input logic [3:0] exp_go, input logic exp_hr);
    apb(1'b1, REG_CTRL, ctrl);
    core_prefetch_done <= pf1;
    @(posedge core_clk);
    core_prefetch_done <= 4'h0;
    go = 4'h0;
    repeat (10)
    begin
      @(posedge core_clk);
      go = go | core_go;
    end
    chk({28'h0, go}, 32'h0);
    core_prefetch_done <= pf2;
    @(posedge core_clk);
    core_prefetch_done <= 4'h0;
    hr = 1'b0;
    nt = 0;
    do
    begin
      @(posedge core_clk);
      hr = hr | hub_ready;
      nt++;
    end
    while (core_go === 4'h0 && nt < 100);
    chk({28'h0, core_go}, {28'h0, exp_go});
    chk({31'h0, hr}, {31'h0, exp_hr});
    n = 0;
    repeat (20)
    begin
      @(posedge core_clk);
      n = n + int'(int_trigger === 1'b1);
    end
  endtask : bar

  task automatic t_bar();
    apb(1'b1, REG_TRIG, 32'h00000203);
    bar(32'h00000302, 4'b0001, 4'b0010, 4'b0011, 1'b0);
    chk(n, 32'h3);
    bar(32'h00000100, 4'b0000, 4'b0100, 4'b0100, 1'b0);
    bar(32'h00000101, 4'b0000, 4'b0001, 4'b0001, 1'b1);
  endtask : t_bar

  task automatic t_rate(input logic [3:0] v, input logic [3:0] exp);
    rate_ovr_exp <= v;
    rate_ovr_valid <= 1'b1;
    @(posedge core_clk);
    rate_ovr_valid <= 1'b0;
    @(posedge core_clk);
    chk({28'h0, rate_exp}, {28'h0, exp});
  endtask : t_rate

  task automatic results();
    $display("fails=%0d cmp_count=%0d", fails, cmp_count);
    if (fails == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : results

  initial
  begin
    repeat (16) @(posedge core_clk);
    resetn <= 1'b1;
    @(posedge core_clk);
    t_regs();
    t_fb();
    t_bar();
    t_rate(4'h5, 4'h5);
    t_rate(4'hE, 4'h5);
    // Override while frozen must be lost
    ce <= 1'b0;
    t_rate(4'h3, 4'h5);
    ce <= 1'b1;
    results();
  end
endmodule : tb
